/* hw/dst_pkg.sv */
// Shared constants for the drive self-test sequencer and its results log.
// Assumes a single 250 MHz clock domain and an AXI4-Lite register port.
package dst_pkg;
  // Clock and time budget
  localparam longint CLK_HZ = 250_000_000;
  localparam longint SHORT_LIMIT_S = 120;
  localparam longint SHORT_LIMIT_CYC = SHORT_LIMIT_S * CLK_HZ;
  localparam int BUDGET_W = 36;

  // Test codes, carried in bits 7:5 as in command byte 1
  localparam int FC_LSB = 5;
  localparam logic [2:0] FC_SHORT = 3'h1;
  localparam logic [2:0] FC_EXT = 3'h2;
  localparam logic [2:0] FC_ABORT = 3'h4;

  // Result values
  localparam logic [3:0] RES_PASS = 4'h0;
  localparam logic [3:0] RES_ABORT = 4'h1;
  localparam logic [3:0] RES_RESET = 4'h2;
  localparam logic [3:0] RES_ELEC = 4'h3;
  localparam logic [3:0] RES_SERVO = 4'h4;
  localparam logic [3:0] RES_SCAN = 4'h5;
  localparam logic [3:0] RES_RUN = 4'hf;

  // Readiness answer
  localparam logic [7:0] SK_NOT_READY = 8'h02;
  localparam logic [7:0] ASC_NOT_READY = 8'h04;
  localparam logic [7:0] ASCQ_CAUSE = 8'h00;
  localparam logic [7:0] ASCQ_MANUAL = 8'h03;

  // Log layout
  localparam int LOG_DEPTH = 20;
  localparam int LBA_W = 32;
  localparam int SENSE_W = 28;

  // Register byte offsets
  localparam logic [7:0] A_CMD = 8'h00;
  localparam logic [7:0] A_STATUS = 8'h04;
  localparam logic [7:0] A_IRQ_STAT = 8'h08;
  localparam logic [7:0] A_IRQ_MASK = 8'h0c;
  localparam logic [7:0] A_READY = 8'h10;
  localparam logic [7:0] A_EXT_TIME = 8'h14;
  localparam logic [7:0] A_LOG_SEL = 8'h18;
  localparam logic [7:0] A_LOG_ENTRY = 8'h1c;
  localparam logic [7:0] A_LOG_LBA = 8'h20;
  localparam logic [7:0] A_LOG_SENSE = 8'h24;
  localparam logic [7:0] A_RECOVERED = 8'h28;

  // Interrupt bits
  localparam int IRQ_W = 4;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_FAIL = 1;
  localparam int IRQ_REFUSED = 2;
  localparam int IRQ_NREADY = 3;

  // Status fields
  localparam int ST_BUSY = 0;
  localparam int ST_NREADY = 1;
  localparam int ST_SEG_LSB = 2;
  localparam int ST_CODE_LSB = 4;
  localparam int ST_COUNT_LSB = 8;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {SEG_ELEC, SEG_SERVO, SEG_SCAN} seg_t;
endpackage

/* hw/dst_results_log.sv */
// Twenty-entry self-test results log, newest entry at index 0.
// Assumes the sequencer pushes once per test and updates only entry 0.
`timescale 1ns/1ps
module dst_results_log
  import dst_pkg::*;
#(
  parameter int DEPTH = LOG_DEPTH,
  parameter int CNT_W = $clog2(DEPTH + 1)
) (
  input wire logic aclk, // Clock
  input wire logic aresetn, // Sync reset, low
  input wire logic ce, // Clock enable
  input wire logic push, // Open a new entry
  input wire logic [2:0] push_code, // Test code of new entry
  input wire logic upd, // Write final outcome to entry 0
  input wire logic [3:0] upd_res, // Final result value
  input wire logic [LBA_W-1:0] upd_lba, // Failing block address
  input wire logic [SENSE_W-1:0] upd_sense, // FRU, ASCQ, ASC, key
  input wire logic [CNT_W-1:0] rd_idx, // Entry to read
  output logic [2:0] rd_code, // Selected entry code
  output logic [3:0] rd_res, // Selected entry result
  output logic [LBA_W-1:0] rd_lba, // Selected entry address
  output logic [SENSE_W-1:0] rd_sense, // Selected entry sense
  output logic [3:0] head_res, // Result of entry 0
  output logic [CNT_W-1:0] count // Valid entries
);
  logic [2:0] code_mem [DEPTH];
  logic [3:0] res_mem [DEPTH];
  logic [LBA_W-1:0] lba_mem [DEPTH];
  logic [SENSE_W-1:0] sense_mem [DEPTH];
  wire idx_ok = rd_idx < CNT_W'(DEPTH) && rd_idx < count;

  // Out-of-range reads show zero instead of stale entries
  assign rd_code = idx_ok ? code_mem[rd_idx] : '0;
  assign rd_res = idx_ok ? res_mem[rd_idx] : '0;
  assign rd_lba = idx_ok ? lba_mem[rd_idx] : '0;
  assign rd_sense = idx_ok ? sense_mem[rd_idx] : '0;
  assign head_res = res_mem[0];

  // Push shifts all entries down; the oldest falls off the end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count <= '0;
      for (int i = 0; i < DEPTH; i++) begin
        code_mem[i] <= '0;
        res_mem[i] <= '0;
        lba_mem[i] <= '0;
        sense_mem[i] <= '0;
      end
    end else if (ce && push) begin
      for (int i = DEPTH - 1; i > 0; i--) begin
        code_mem[i] <= code_mem[i-1];
        res_mem[i] <= res_mem[i-1];
        lba_mem[i] <= lba_mem[i-1];
        sense_mem[i] <= sense_mem[i-1];
      end
      code_mem[0] <= push_code;
      res_mem[0] <= RES_RUN;
      lba_mem[0] <= '0;
      sense_mem[0] <= '0;
      if (count < CNT_W'(DEPTH)) begin
        count <= count + 1'b1;
      end
    end else if (ce && upd) begin
      res_mem[0] <= upd_res;
      lba_mem[0] <= upd_lba;
      sense_mem[0] <= upd_sense;
    end
  end

  a_count_cap: assert property (@(posedge aclk) disable iff (!aresetn)
    count <= CNT_W'(DEPTH))
    else $error("log count above depth");
endmodule

/* hw/dst_sequencer.sv */
// Drive self-test sequencer: command decode, segment sequencing, result
// logging with non-volatile commits, readiness answer, AXI4-Lite registers.
// Assumes a segment engine and an NVM writer on aclk; fault pins are async.
//
// Chosen here: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
module dst_sequencer
  import dst_pkg::*;
#(
  parameter logic [BUDGET_W-1:0] SHORT_CYC = BUDGET_W'(SHORT_LIMIT_CYC),
  parameter logic [LBA_W-1:0] MAX_LBA = 32'h0100_0000,
  parameter logic [LBA_W-1:0] SHORT_LBAS = 32'h0001_0000,
  parameter logic [15:0] EXT_MINUTES = 16'h00b4
) (
  input wire logic aclk, // Clock, 250 MHz
  input wire logic aresetn, // Sync reset, low
  input wire logic ce, // Clock enable
  input wire logic [7:0] awaddr, // Write address
  input wire logic awvalid, // Write address valid
  output logic awready, // Write address ready
  input wire logic [31:0] wdata, // Write data
  input wire logic [3:0] wstrb, // Write strobes
  input wire logic wvalid, // Write data valid
  output logic wready, // Write data ready
  output logic [1:0] bresp, // Write response
  output logic bvalid, // Write response valid
  input wire logic bready, // Write response ready
  input wire logic [7:0] araddr, // Read address
  input wire logic arvalid, // Read address valid
  output logic arready, // Read address ready
  output logic [31:0] rdata, // Read data
  output logic [1:0] rresp, // Read response
  output logic rvalid, // Read data valid
  input wire logic rready, // Read data ready
  output logic irq, // Level interrupt
  input wire logic spindle_fault_pin, // Motor will not spin or lock
  input wire logic servo_unlock_pin, // Servo off track
  input wire logic config_bad_pin, // Config tables unreadable
  input wire logic bus_reset_pin, // Bus or device reset
  output logic seg_go, // Start segment, pulse
  output seg_t seg_sel, // Segment to run
  output logic [LBA_W-1:0] scan_count, // Blocks to scan
  output logic seg_stop, // Stop engine, pulse
  input wire logic seg_done, // Segment finished, pulse
  input wire logic seg_fail, // Unrecovered error at done
  input wire logic [LBA_W-1:0] fail_lba, // Failing block
  input wire logic [3:0] fail_key, // Sense key
  input wire logic [7:0] fail_asc, // ASC
  input wire logic [7:0] fail_ascq, // ASCQ
  input wire logic [7:0] fail_fru, // FRU
  input wire logic rec_event, // Error corrected by retry
  output logic nvm_save, // Commit log, pulse
  input wire logic nvm_done // Commit finished, pulse
);
  localparam int CNT_W = $clog2(LOG_DEPTH + 1);
  typedef enum logic [2:0] {S_IDLE, S_INIT_NV, S_RUN, S_FINISH, S_FINAL_NV} state_t;

  state_t state;
  seg_t seg;
  logic [2:0] code;
  logic [3:0] result;
  logic [LBA_W-1:0] res_lba;
  logic [SENSE_W-1:0] res_sense;
  logic [BUDGET_W-1:0] budget;
  logic abort_pend, reset_pend;
  logic [IRQ_W-1:0] irq_stat, irq_mask;
  logic [CNT_W-1:0] log_sel;
  logic [31:0] recovered;
  logic [3:0] pin_s1, pin_s2, pin_s3, pin_q;
  logic aw_held, w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic w_lane0;

  // Three-stage pin synchroniser; level moves once stages two and three agree
  wire [3:0] pin_raw = {bus_reset_pin, config_bad_pin, servo_unlock_pin, spindle_fault_pin};
  wire [3:0] pin_agree = ~(pin_s2 ^ pin_s3);
  wire [3:0] next_pin_q = (pin_agree & pin_s3) | (~pin_agree & pin_q);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_s1 <= '0;
      pin_s2 <= '0;
      pin_s3 <= '0;
      pin_q <= '0;
    end else if (ce) begin
      pin_s1 <= pin_raw;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      pin_q <= next_pin_q;
    end
  end

  // Readiness and the answer a readiness query gets
  wire not_ready = |pin_q[2:0];
  wire reset_evt = next_pin_q[3] & ~pin_q[3];
  wire [7:0] rdy_ascq = pin_q[0] ? ASCQ_CAUSE : ASCQ_MANUAL;
  wire [31:0] ready_sense = not_ready ?
    {8'h00, SK_NOT_READY, ASC_NOT_READY, rdy_ascq} : 32'h0000_0000;

  // AXI write: address and data taken in either order
  wire aw_take = awvalid && awready;
  wire w_take = wvalid && wready;
  wire wr_fire = aw_held && w_held && !bvalid;
  wire wr_lane = w_lane0;
  wire [7:0] wr_addr = aw_addr;
  wire wr_hit = wr_addr == A_CMD || wr_addr == A_IRQ_STAT
    || wr_addr == A_IRQ_MASK || wr_addr == A_LOG_SEL;
  wire wr_cmd = wr_fire && wr_lane && wr_addr == A_CMD;
  wire [2:0] cmd_code = w_data[FC_LSB +: 3];
  wire busy = state != S_IDLE;
  wire cmd_test = cmd_code == FC_SHORT || cmd_code == FC_EXT;
  // Host is expected to check readiness first; refusal is flagged anyway
  wire start_ok = wr_cmd && cmd_test && !busy && !not_ready;
  wire abort_ok = wr_cmd && cmd_code == FC_ABORT && busy;
  wire refused = wr_cmd && !start_ok && !abort_ok;
  wire [IRQ_W-1:0] irq_clr = (wr_fire && wr_lane && wr_addr == A_IRQ_STAT) ?
    w_data[IRQ_W-1:0] : '0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= '0;
      w_data <= '0;
      w_lane0 <= 1'b0;
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end else if (ce) begin
      awready <= !aw_held && !aw_take;
      wready <= !w_held && !w_take;
      if (aw_take) begin
        aw_held <= 1'b1;
        aw_addr <= awaddr;
      end
      if (w_take) begin
        w_held <= 1'b1;
        w_data <= wdata;
        w_lane0 <= wstrb[0];
      end
      if (wr_fire) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        bvalid <= 1'b1;
        bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
        awready <= 1'b1;
        wready <= 1'b1;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // Log instance and its read selection
  logic [2:0] lg_code;
  logic [3:0] lg_res, head_res;
  logic [LBA_W-1:0] lg_lba;
  logic [SENSE_W-1:0] lg_sense;
  logic [CNT_W-1:0] log_count;
  wire log_push = ce && start_ok;
  wire log_upd = ce && state == S_FINISH;

  dst_results_log #(.DEPTH(LOG_DEPTH), .CNT_W(CNT_W)) u_log (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .push(log_push),
    .push_code(cmd_code),
    .upd(log_upd),
    .upd_res(result),
    .upd_lba(res_lba),
    .upd_sense(res_sense),
    .rd_idx(log_sel),
    .rd_code(lg_code),
    .rd_res(lg_res),
    .rd_lba(lg_lba),
    .rd_sense(lg_sense),
    .head_res(head_res),
    .count(log_count)
  );

  // Read decode; unmapped addresses answer SLVERR with zero data
  wire [31:0] status_word = 32'({log_count, 1'b0, code, seg, not_ready, busy});
  wire rd_hit = araddr <= A_RECOVERED && araddr[1:0] == 2'b00;
  wire [31:0] rd_val =
    araddr == A_CMD ? 32'({code, 5'h00}) :
    araddr == A_STATUS ? status_word :
    araddr == A_IRQ_STAT ? 32'(irq_stat) :
    araddr == A_IRQ_MASK ? 32'(irq_mask) :
    araddr == A_READY ? ready_sense :
    araddr == A_EXT_TIME ? 32'(EXT_MINUTES) :
    araddr == A_LOG_SEL ? 32'(log_sel) :
    araddr == A_LOG_ENTRY ? 32'({lg_code, lg_res}) :
    araddr == A_LOG_LBA ? lg_lba :
    araddr == A_LOG_SENSE ? 32'(lg_sense) :
    araddr == A_RECOVERED ? recovered : 32'h0000_0000;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= RESP_OKAY;
    end else if (ce) begin
      arready <= !rvalid && !(arvalid && arready);
      if (arvalid && arready) begin
        rvalid <= 1'b1;
        rdata <= rd_hit ? rd_val : 32'h0000_0000;
        rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid && rready) begin
        rvalid <= 1'b0;
        arready <= 1'b1;
      end
    end
  end

  // Interrupt status: set wins over a write-one clear in the same cycle
  wire fin_nv = state == S_FINAL_NV && nvm_done;
  wire went_nready = |next_pin_q[2:0] && !not_ready;
  wire [IRQ_W-1:0] irq_set = {went_nready, refused, fin_nv && result >= RES_ELEC, fin_nv};
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat <= '0;
      irq_mask <= '0;
      irq <= 1'b0;
      log_sel <= '0;
      recovered <= '0;
    end else if (ce) begin
      irq_stat <= (irq_stat & ~irq_clr) | irq_set;
      irq <= |(irq_stat & irq_mask);
      if (wr_fire && wr_lane && wr_addr == A_IRQ_MASK) begin
        irq_mask <= w_data[IRQ_W-1:0];
      end
      if (wr_fire && wr_lane && wr_addr == A_LOG_SEL) begin
        log_sel <= w_data[CNT_W-1:0];
      end
      if (rec_event && state == S_RUN) begin
        recovered <= recovered + 1'b1;
      end
    end
  end

  // Segment result to failure code; only unrecovered errors reach here
  function automatic logic [3:0] seg_res(seg_t s);
    case (s)
      SEG_ELEC: seg_res = RES_ELEC;
      SEG_SERVO: seg_res = RES_SERVO;
      default: seg_res = RES_SCAN;
    endcase
  endfunction

  wire is_short = code == FC_SHORT;
  wire out_of_time = is_short && budget == '0;
  wire [LBA_W-1:0] scan_len = is_short ? SHORT_LBAS : MAX_LBA;

  // Sequencer; abort and reset requests are latched and acted on while running
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= S_IDLE;
      seg <= SEG_ELEC;
      seg_sel <= SEG_ELEC;
      code <= '0;
      result <= RES_PASS;
      res_lba <= '0;
      res_sense <= '0;
      budget <= '0;
      abort_pend <= 1'b0;
      reset_pend <= 1'b0;
      seg_go <= 1'b0;
      seg_stop <= 1'b0;
      scan_count <= '0;
      nvm_save <= 1'b0;
    end else if (ce) begin
      seg_go <= 1'b0;
      seg_stop <= 1'b0;
      nvm_save <= 1'b0;
      if (busy && abort_ok) begin
        abort_pend <= 1'b1;
      end
      if (busy && reset_evt) begin
        reset_pend <= 1'b1;
      end
      if (busy && budget != '0) begin
        budget <= budget - 1'b1;
      end
      case (state)
        S_IDLE: begin
          if (start_ok) begin
            code <= cmd_code;
            result <= RES_RUN;
            res_lba <= '0;
            res_sense <= '0;
            budget <= SHORT_CYC;
            abort_pend <= 1'b0;
            reset_pend <= 1'b0;
            nvm_save <= 1'b1;
            state <= S_INIT_NV;
          end
        end
        S_INIT_NV: begin
          if (nvm_done) begin
            seg <= SEG_ELEC;
            seg_sel <= SEG_ELEC;
            seg_go <= 1'b1;
            state <= S_RUN;
          end
        end
        S_RUN: begin
          if (reset_pend) begin
            result <= RES_RESET;
            seg_stop <= 1'b1;
            state <= S_FINISH;
          end else if (abort_pend) begin
            result <= RES_ABORT;
            seg_stop <= 1'b1;
            state <= S_FINISH;
          end else if (seg_done && seg_fail) begin
            result <= seg_res(seg);
            res_lba <= fail_lba;
            res_sense <= {fail_fru, fail_ascq, fail_asc, fail_key};
            state <= S_FINISH;
          end else if (out_of_time) begin
            result <= RES_PASS;
            seg_stop <= 1'b1;
            state <= S_FINISH;
          end else if (seg_done) begin
            if (seg == SEG_SCAN) begin
              result <= RES_PASS;
              state <= S_FINISH;
            end else begin
              seg <= seg == SEG_ELEC ? SEG_SERVO : SEG_SCAN;
              seg_sel <= seg == SEG_ELEC ? SEG_SERVO : SEG_SCAN;
              scan_count <= scan_len;
              seg_go <= 1'b1;
            end
          end
        end
        S_FINISH: begin
          nvm_save <= 1'b1;
          state <= S_FINAL_NV;
        end
        S_FINAL_NV: begin
          if (nvm_done) begin
            abort_pend <= 1'b0;
            reset_pend <= 1'b0;
            state <= S_IDLE;
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_code_select: assert property (ce && start_ok |=> code == $past(cmd_code)
    && state == S_INIT_NV)
    else $error("test code not taken");
  a_short_budget: assert property (ce && state == S_RUN && out_of_time && !seg_done
    && !abort_pend && !reset_pend |=> state == S_FINISH && result == RES_PASS)
    else $error("short test overran budget");
  a_scan_short: assert property (seg_go && seg_sel == SEG_SCAN && is_short
    |-> scan_count == SHORT_LBAS)
    else $error("short scan length wrong");
  a_scan_ext: assert property (seg_go && seg_sel == SEG_SCAN && !is_short
    |-> scan_count == MAX_LBA)
    else $error("extended scan length wrong");
  a_seg_order: assert property (ce && state == S_RUN && seg == SEG_ELEC && seg_done
    && !seg_fail && !out_of_time && !abort_pend && !reset_pend
    |=> seg_go && seg_sel == SEG_SERVO)
    else $error("segment order broken");
  a_new_entry: assert property (log_push |=> head_res == RES_RUN && nvm_save)
    else $error("new entry not in progress");
  a_final_commit: assert property (ce && state == S_FINISH |=> head_res == result
    && nvm_save)
    else $error("outcome not committed");
  a_fail_unrec: assert property (ce && state == S_RUN && seg_done && seg_fail
    && !abort_pend && !reset_pend |=> result == seg_res(seg) && result != RES_PASS)
    else $error("failure code wrong");
  a_rec_pass: assert property (ce && state == S_RUN && seg == SEG_SCAN && seg_done
    && !seg_fail && !out_of_time && !abort_pend && !reset_pend
    |=> result == RES_PASS)
    else $error("recovered run not a pass");
  a_abort_code: assert property (ce && state == S_RUN && abort_pend && !reset_pend
    |=> result == RES_ABORT ##1 nvm_save)
    else $error("abort result wrong");
  a_reset_code: assert property (ce && state == S_RUN && reset_pend
    |=> result == RES_RESET)
    else $error("reset result wrong");
  a_not_ready: assert property (not_ready |-> ready_sense[23:16] == SK_NOT_READY
    && ready_sense[15:8] == ASC_NOT_READY)
    else $error("not ready answer wrong");
  a_hold_prog: assert property (state == S_RUN |-> head_res == RES_RUN)
    else $error("result left Fh while running");

  c_short_pass: cover property (state == S_FINAL_NV && is_short && result == RES_PASS);
  c_ext_fail: cover property (state == S_FINISH && !is_short && result == RES_SCAN);
  c_abort: cover property (state == S_FINISH && result == RES_ABORT);
  c_reset: cover property (state == S_FINISH && result == RES_RESET);
endmodule

/* bench/dst_engine_model.sv */
// Segment engine and log commit partner of the self-test sequencer.
// Assumes one-cycle seg_go, seg_stop and nvm_save pulses on aclk.
`timescale 1ns/1ps
module dst_engine_model
  import dst_pkg::*;
(
  input wire logic aclk, // Clock
  input wire logic seg_go, // Segment start
  input wire seg_t seg_sel, // Segment kind
  input wire logic seg_stop, // Stop request
  input wire logic nvm_save, // Commit request
  input wire logic [1:0] fail_seg, // Failing segment, 3 none
  input wire logic [9:0] dly, // Cycles per segment
  output logic seg_done, // Segment end
  output logic seg_fail, // Unrecovered error
  output logic rec_event, // Corrected error
  output logic nvm_done // Commit end
);
  int cnt = 0;
  int nvm_cnt = 0;
  seg_t cur = SEG_ELEC;

  // Quiet outputs before the first edge
  initial begin
    seg_done = 0;
    seg_fail = 0;
    rec_event = 0;
    nvm_done = 0;
  end

  // Commit takes three cycles; a stop kills the segment with no done
  always @(posedge aclk) begin
    nvm_done <= (nvm_cnt == 1);
    seg_done <= (cnt == 1);
    seg_fail <= (cnt == 1) && (cur == fail_seg);
    rec_event <= (cnt == 2);
    if (nvm_save) nvm_cnt <= 3;
    else if (nvm_cnt > 0) nvm_cnt <= nvm_cnt - 1;
    if (seg_stop) cnt <= 0;
    else if (seg_go) cnt <= dly;
    else if (cnt > 0) cnt <= cnt - 1;
    if (seg_go) cur <= seg_sel;
  end
endmodule

/* bench/drive_self_test_sequencer_bench.sv */
// Bench of the self-test sequencer: AXI4-Lite host tasks and scenarios.
// Assumes dst_engine_model answers segments and log commits.
`timescale 1ns/1ps
module drive_self_test_sequencer_bench import dst_pkg::*; ;
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0;
  logic rready = 0, spindle_fault_pin = 0, servo_unlock_pin = 0, config_bad_pin = 0;
  logic bus_reset_pin = 0, stops = 0, ce = 1;
  logic [7:0] awaddr = 0, araddr = 0, fail_asc = 0, fail_ascq = 0, fail_fru = 0;
  logic [31:0] wdata = 0, fail_lba = 0, rd_v, ist, rdata, scan_count, sc;
  logic [1:0] fail_seg = 3, bresp, rresp, resp;
  logic [3:0] fail_key = 0, wstrb = 4'hf;
  logic [9:0] dly = 20;
  logic [5:0] ord;
  logic awready, wready, bvalid, arready, rvalid, irq, seg_go, seg_stop;
  logic seg_done, seg_fail, rec_event, nvm_save, nvm_done;
  seg_t seg_sel;
  int errors = 0, checked = 0, n;
  always #2 aclk = ~aclk;

  dst_sequencer #(.SHORT_CYC(36'h190), .MAX_LBA(32'h0000_0100), .SHORT_LBAS(32'h0000_0010),
    .EXT_MINUTES(16'h002a)) dut (.aclk, .aresetn, .ce, .awaddr, .awvalid, .awready,
    .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
    .arready, .rdata, .rresp, .rvalid, .rready, .irq, .spindle_fault_pin, .servo_unlock_pin,
    .config_bad_pin, .bus_reset_pin, .seg_go, .seg_sel, .scan_count, .seg_stop, .seg_done,
    .seg_fail, .fail_lba, .fail_key, .fail_asc, .fail_ascq, .fail_fru, .rec_event,
    .nvm_save, .nvm_done);
  dst_engine_model eng (.aclk, .seg_go, .seg_sel, .seg_stop, .nvm_save, .fail_seg, .dly,
    .seg_done, .seg_fail, .rec_event, .nvm_done);

  // Segment order and scan length as launched
  always @(posedge aclk) begin
    if (seg_go) ord <= {ord[3:0], 2'(seg_sel)};
    if (seg_go && seg_sel == SEG_SCAN) sc <= scan_count;
    if (seg_stop) stops <= 1;
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s exp %h got %h", nm, e, g);
    end
  endtask

  task automatic end_sim();
    if (errors == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // Bus tasks start just after an edge; each channel held until taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
    end while (awvalid && !awready || wvalid && !wready);
    do @(posedge aclk); while (bvalid !== 1'b1);
    bready <= 0;
    resp = bresp;
    @(posedge aclk); // One edge between transfers, so bready is not set twice at once
  endtask

  task automatic rd(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rready <= 0;
    rd_v = rdata;
    resp = rresp;
    @(posedge aclk); // One edge between transfers
  endtask

  task automatic start(input logic [2:0] c);
    wr(A_CMD, {24'h0, c, 5'h0});
  endtask

  task automatic entry(input logic [4:0] i);
    wr(A_LOG_SEL, {27'h0, i});
    rd(A_LOG_ENTRY);
  endtask

  // Done interrupt, then status snapshot and clear
  task automatic done_wait();
    do @(posedge aclk); while (irq !== 1'b1);
    rd(A_IRQ_STAT);
    ist = rd_v;
    wr(A_IRQ_STAT, 32'h0000_000f);
  endtask

  task automatic t_idle();
    rd(A_EXT_TIME);
    chk("ext_time", 32'h0000_002a, rd_v);
    rd(8'h40);
    chk("unmapped", 32'h0000_0002, {30'h0, resp});
    wr(A_STATUS, 32'h0000_0000);
    chk("wr_ro", 32'h0000_0002, {30'h0, resp});
    wr(A_IRQ_MASK, 32'h0000_0001);
  endtask

  task automatic t_short();
    rd(A_READY);
    chk("ready", 32'h0, rd_v);
    ord = 0;
    start(FC_SHORT);
    entry(0);
    chk("run_entry", 32'h0000_001f, rd_v);
    done_wait();
    entry(0);
    chk("short_entry", 32'h0000_0010, rd_v);
    chk("order", 32'h0000_0006, {26'h0, ord});
    chk("short_scan", 32'h0000_0010, sc);
    rd(A_RECOVERED);
    chk("recovered", 32'h0000_0003, rd_v);
    chk("irq_clear", 32'h0, {31'h0, irq});
  endtask

  task automatic t_fail();
    fail_seg <= 2;
    fail_lba <= 32'h0000_0077;
    fail_key <= 4'h3;
    fail_asc <= 8'h11;
    fail_ascq <= 8'h04;
    fail_fru <= 8'h5a;
    start(FC_EXT);
    done_wait();
    fail_seg <= 3;
    chk("fail_irq", 32'h0000_0003, ist);
    chk("ext_scan", 32'h0000_0100, sc);
    entry(0);
    chk("fail_entry", 32'h0000_0025, rd_v);
    rd(A_LOG_LBA);
    chk("fail_lba", 32'h0000_0077, rd_v);
    rd(A_LOG_SENSE);
    chk("fail_sense", 32'h05a0_4113, rd_v);
    entry(1);
    chk("shifted", 32'h0000_0010, rd_v);
  endtask

  // Abort by code, then by bus reset, both mid-segment
  task automatic t_stop();
    dly <= 300;
    start(FC_EXT);
    repeat (100) @(posedge aclk);
    start(FC_ABORT);
    done_wait();
    entry(0);
    chk("abort_entry", 32'h0000_0021, rd_v);
    start(FC_SHORT);
    repeat (100) @(posedge aclk);
    bus_reset_pin <= 1;
    repeat (6) @(posedge aclk);
    bus_reset_pin <= 0;
    done_wait();
    entry(0);
    chk("reset_entry", 32'h0000_0012, rd_v);
  endtask

  task automatic t_time();
    stops <= 0;
    start(FC_SHORT);
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (irq !== 1'b1);
    done_wait();
    dly <= 3;
    chk("short_time", 32'h1, {31'h0, n <= 460});
    chk("stop_seen", 32'h1, {31'h0, stops});
    entry(0);
    chk("time_entry", 32'h0000_0010, rd_v);
  endtask

  task automatic t_full();
    repeat (17) begin
      start(FC_SHORT);
      done_wait();
    end
    rd(A_STATUS);
    chk("log_count", 32'h0000_0014, {27'h0, rd_v[12:8]});
    entry(19);
    chk("oldest", 32'h0000_0021, rd_v);
    entry(20);
    chk("dropped", 32'h0, rd_v);
  endtask

  task automatic t_nready();
    spindle_fault_pin <= 1;
    repeat (8) @(posedge aclk);
    rd(A_READY);
    chk("ready_spin", 32'h0002_0400, rd_v);
    start(FC_SHORT);
    rd(A_IRQ_STAT);
    chk("refused", 32'h0000_000c, rd_v & 32'h0000_000c);
    spindle_fault_pin <= 0;
    for (int i = 0; i < 2; i++) begin
      servo_unlock_pin <= (i == 0);
      config_bad_pin <= (i == 1);
      repeat (8) @(posedge aclk);
      rd(A_READY);
      chk("ready_trk", 32'h0002_0403, rd_v);
    end
  endtask

  // Masked lane and a frozen clock enable must both leave the block untouched
  task automatic t_freeze();
    wstrb <= 4'h0;
    start(FC_SHORT);
    wstrb <= 4'hf;
    chk("strb_resp", 32'h0, {30'h0, resp});
    rd(A_STATUS);
    chk("strb_busy", 32'h0, {31'h0, rd_v[0]});
    ce <= 0;
    spindle_fault_pin <= 1;
    repeat (10) @(posedge aclk);
    ce <= 1;
    spindle_fault_pin <= 0;
    rd(A_IRQ_STAT);
    chk("frozen_pin", 32'h0, rd_v & 32'h0000_0008);
  endtask

  // Watchdog well past the longest expected run
  initial begin
    repeat (60000) @(posedge aclk);
    errors++;
    end_sim();
  end

  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1;
    repeat (4) @(posedge aclk);
    t_idle();
    t_short();
    t_fail();
    t_stop();
    t_time();
    t_full();
    t_freeze();
    t_nready();
    end_sim();
  end
endmodule
